// ===== core/rf_pll_modulation_config.sv
// Synthesizer and modulation configuration registers with Wishbone slave.
`timescale 1ns/10ps
`default_nettype none
//
// Function
// RL1: Divider and coding bytes reach software only while the page bit is zero.
// RL2: Zero-symbol word, split 12:5 and 4:0, sets FSK zero ratio base+w/8192.
// RL3: One-symbol word, split likewise, sets ratio for a one in OOK and FSK.
// RL4: Soft reset clears both words, invert, coding, band and keying fields.
// RL5: Invert bit zero passes data straight, one inverts it and swaps symbols.
// RL6: Coding 00 Manchester, 01 Bi-Phase, 10 NRZ, 11 direct data bit.
// RL7: NRZ mode sends buffer bits at twice the rate to build mixed content.
// RL8: Band bit zero gives integer base 12, one gives base 16.
// RL9: Keying bit zero selects on-off keying, one selects frequency shift.
// RL10: Reference enable drives a 500 kHz timer clock, otherwise held low.
// RL11: Writing one to soft reset resets the module; it always reads zero.
// RL12: Page bit chooses divider page or the upper data buffer page.
// RL13: Soft reset also clears the timer reference enable bit.
module rf_pll_modulation_config
   import rf_pll_cfg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Wishbone classic slave.
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Page one window, served by the data buffer outside.
   input  wire logic [7:0]  alt_page_rdata,
   output logic             alt_page_wr,
   output logic             alt_page_rd,
   output logic      [7:0]  alt_page_addr,
   output logic      [7:0]  alt_page_wdata,
   // Bit stream from the data buffer and its rate.
   input  wire logic        half_bit_tick,
   input  wire logic        buffer_bit,
   output logic             buffer_bit_take,
   // Configuration seen by the rest of the transmitter.
   output logic             transmitter_soft_reset,
   output logic             register_page_select,
   output logic      [12:0] zero_symbol_divider_fraction,
   output logic      [12:0] one_symbol_divider_fraction,
   output logic             carrier_band_select,
   output logic             keying_method_select,
   output logic             output_invert_select,
   output logic      [1:0]  coding_select,
   output logic             timer_reference_enable,
   // Synthesizer drive and modulated data.
   output logic      [4:0]  divider_integer,
   output logic      [12:0] divider_fraction,
   output logic             carrier_enable,
   output logic             rf_data,
   output logic             timer_reference_clock
);

   // Configuration state.
   logic [12:0] zero_frac_reg;
   logic [12:0] one_frac_reg;
   logic        invert_reg;
   coding_t     coding_reg;
   logic        band_reg;
   logic        keying_reg;
   logic        ref_en_reg;
   logic        page_reg;
   logic        direct_reg;
   logic        srst_pulse_reg;

   // Bus state.
   logic        ack_reg;
   logic [31:0] rdata_reg;
   logic        alt_wr_reg;
   logic        alt_rd_reg;
   logic [7:0]  alt_addr_reg;
   logic [7:0]  alt_wdata_reg;

   // Synthesizer and reference state.
   logic [4:0]  div_int_reg;
   logic [12:0] div_frac_reg;
   logic        carrier_reg;
   logic [5:0]  ref_cnt_reg;
   logic        ref_clk_reg;

   // Decoded accesses.
   logic        req;
   logic        wr_en;
   logic        rd_en;
   logic        byte_wr;
   logic        srst_wr;
   logic        symbol_level;

   // True for the four shared addresses of the divider page.
   function automatic logic is_shared(input logic [7:0] adr);
      is_shared = (adr[7:2] == ZERO_HIGH_OFS[7:2]) ||
                  (adr[7:2] == ZERO_LOW_OFS[7:2])  ||
                  (adr[7:2] == ONE_HIGH_OFS[7:2])  ||
                  (adr[7:2] == ONE_LOW_OFS[7:2]);
   endfunction : is_shared

   // Compare a word address against a register offset.
   function automatic logic hit(input logic [7:0] adr,
                                input logic [7:0] ofs);
      hit = (adr[7:2] == ofs[7:2]);
   endfunction : hit

   // A request is served once; ack drops the cycle after it is given.
   assign req     = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr_en   = req & wb_we_i;
   assign rd_en   = req & ~wb_we_i;
   assign byte_wr = wr_en & wb_sel_i[0];
   assign srst_wr = byte_wr & hit(wb_adr_i, CONTROL_OFS)
                    & wb_dat_i[CTRL_SRST_BIT];

   // Acknowledge every access, mapped or not, one cycle after the request.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req;
      end
   end

   // Divider and coding bytes; writes land only while page zero is shown.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         zero_frac_reg <= FRAC_RST;
         one_frac_reg  <= FRAC_RST;
         invert_reg    <= INVERT_RST;
         coding_reg    <= CODE_MANCHESTER;
         band_reg      <= BAND_RST;
         keying_reg    <= KEYING_RST;
         ref_en_reg    <= REF_EN_RST;
      end else if (srst_wr) begin
         zero_frac_reg <= FRAC_RST; // RL4
         one_frac_reg  <= FRAC_RST; // RL4
         invert_reg    <= INVERT_RST; // RL4
         coding_reg    <= CODE_MANCHESTER; // RL4
         band_reg      <= BAND_RST; // RL4
         keying_reg    <= KEYING_RST; // RL4
         ref_en_reg    <= REF_EN_RST; // RL13
      end else if (byte_wr && !page_reg) begin // RL1
         if (hit(wb_adr_i, ZERO_HIGH_OFS)) begin
            zero_frac_reg[12:5] <= wb_dat_i[7:0]; // RL2
         end else if (hit(wb_adr_i, ZERO_LOW_OFS)) begin
            zero_frac_reg[4:0] <= wb_dat_i[7:3]; // RL2
            invert_reg <= wb_dat_i[INVERT_BIT];
            coding_reg <= coding_t'(wb_dat_i[1:0]);
         end else if (hit(wb_adr_i, ONE_HIGH_OFS)) begin
            one_frac_reg[12:5] <= wb_dat_i[7:0]; // RL3
         end else if (hit(wb_adr_i, ONE_LOW_OFS)) begin
            one_frac_reg[4:0] <= wb_dat_i[7:3]; // RL3
            band_reg   <= wb_dat_i[BAND_BIT];
            keying_reg <= wb_dat_i[KEYING_BIT];
            ref_en_reg <= wb_dat_i[REF_EN_BIT];
         end
      end
   end

   // Page select and direct data bit; soft reset returns to page zero.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         page_reg   <= PAGE_RST;
         direct_reg <= DIRECT_RST;
      end else if (srst_wr) begin
         page_reg   <= PAGE_RST;
         direct_reg <= DIRECT_RST;
      end else if (byte_wr && hit(wb_adr_i, CONTROL_OFS)) begin
         page_reg   <= wb_dat_i[CTRL_PAGE_BIT]; // RL12
         direct_reg <= wb_dat_i[CTRL_DIRECT_BIT];
      end
   end

   // The soft reset bit is only a strobe; no control bit keeps it, so it reads
   // as zero; srst_pulse_reg holds it for one cycle and the system reset clears that.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         srst_pulse_reg <= 1'b0;
      end else begin
         srst_pulse_reg <= srst_wr; // RL11
      end
   end

   // Page one traffic at the shared addresses goes to the buffer window.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         alt_wr_reg    <= 1'b0;
         alt_rd_reg    <= 1'b0;
         alt_addr_reg  <= 8'h00;
         alt_wdata_reg <= 8'h00;
      end else begin
         alt_wr_reg <= byte_wr & page_reg & is_shared(wb_adr_i); // RL12
         alt_rd_reg <= rd_en & page_reg & is_shared(wb_adr_i); // RL12
         if (req && page_reg && is_shared(wb_adr_i)) begin
            alt_addr_reg  <= wb_adr_i;
            alt_wdata_reg <= wb_dat_i[7:0];
         end
      end
   end

   // Read data, captured with the acknowledge; unmapped words read zero.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_reg <= 32'h0000_0000;
      end else if (rd_en) begin
         rdata_reg <= 32'h0000_0000;
         if (is_shared(wb_adr_i) && page_reg) begin
            // Page one data arrives late; it is merged on the ack cycle.
            rdata_reg <= 32'h0000_0000;
         end else if (hit(wb_adr_i, ZERO_HIGH_OFS)) begin
            rdata_reg[7:0] <= zero_frac_reg[12:5]; // RL1
         end else if (hit(wb_adr_i, ZERO_LOW_OFS)) begin
            rdata_reg[7:0] <= {zero_frac_reg[4:0], invert_reg,
                               coding_reg};
         end else if (hit(wb_adr_i, ONE_HIGH_OFS)) begin
            rdata_reg[7:0] <= one_frac_reg[12:5];
         end else if (hit(wb_adr_i, ONE_LOW_OFS)) begin
            rdata_reg[7:0] <= {one_frac_reg[4:0], band_reg,
                               keying_reg, ref_en_reg};
         end else if (hit(wb_adr_i, CONTROL_OFS)) begin
            rdata_reg[CTRL_PAGE_BIT]   <= page_reg;
            rdata_reg[CTRL_DIRECT_BIT] <= direct_reg;
         end else if (hit(wb_adr_i, STATUS_OFS)) begin
            rdata_reg[STAT_REF_BIT]     <= ref_clk_reg;
            rdata_reg[STAT_DATA_BIT]    <= symbol_level;
            rdata_reg[STAT_CARRIER_BIT] <= carrier_reg;
         end
      end
   end

   // The buffer answers a page one read in the ack cycle from its registers.
   assign wb_dat_o = alt_rd_reg ? {24'h00_0000, alt_page_rdata} : rdata_reg;
   assign wb_ack_o = ack_reg;

   // Line encoder for buffer and direct data.
   symbol_encoder u_encoder (
      .clk           (clk),
      .sys_rst       (sys_rst),
      .soft_clear    (srst_wr),
      .half_bit_tick (half_bit_tick),
      .buffer_bit    (buffer_bit),
      .direct_bit    (direct_reg),
      .invert        (invert_reg),
      .coding        (coding_reg),
      .bit_take      (buffer_bit_take),
      .symbol_level  (symbol_level)
   );

   // Divider for the current symbol: FSK switches between the two words,
   // OOK keeps the one word and gates the carrier instead.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_int_reg  <= INT_BASE_LOW;
         div_frac_reg <= FRAC_RST;
         carrier_reg  <= 1'b0;
      end else begin
         div_int_reg <= band_reg ? INT_BASE_LOW + INT_BASE_STEP
                                 : INT_BASE_LOW; // RL8
         if (keying_reg) begin
            div_frac_reg <= symbol_level ? one_frac_reg
                                         : zero_frac_reg; // RL9
            carrier_reg  <= 1'b1;
         end else begin
            div_frac_reg <= one_frac_reg; // RL3
            carrier_reg  <= symbol_level; // RL9
         end
      end
   end

   // Reference divider: toggles every half period while enabled. A stopped
   // reference parks low so the timer never sees a runt pulse on restart.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ref_cnt_reg <= 6'h00;
         ref_clk_reg <= 1'b0;
      end else if (!ref_en_reg) begin
         ref_cnt_reg <= 6'h00; // RL10
         ref_clk_reg <= 1'b0; // RL10
      end else if (ref_cnt_reg == 6'(REF_HALF_CYCLES - 1)) begin
         ref_cnt_reg <= 6'h00;
         ref_clk_reg <= ~ref_clk_reg; // RL10
      end else begin
         ref_cnt_reg <= ref_cnt_reg + 6'h01;
      end
   end

   // Outputs straight from the registers.
   assign alt_page_wr                  = alt_wr_reg;
   assign alt_page_rd                  = alt_rd_reg;
   assign alt_page_addr                = alt_addr_reg;
   assign alt_page_wdata               = alt_wdata_reg;
   assign transmitter_soft_reset       = srst_pulse_reg;
   assign register_page_select         = page_reg;
   assign zero_symbol_divider_fraction = zero_frac_reg;
   assign one_symbol_divider_fraction  = one_frac_reg;
   assign carrier_band_select          = band_reg;
   assign keying_method_select         = keying_reg;
   assign output_invert_select         = invert_reg;
   assign coding_select                = coding_reg;
   assign timer_reference_enable       = ref_en_reg;
   assign divider_integer              = div_int_reg;
   assign divider_fraction             = div_frac_reg;
   assign carrier_enable               = carrier_reg;
   assign rf_data                      = symbol_level;
   assign timer_reference_clock        = ref_clk_reg;

endmodule : rf_pll_modulation_config
`default_nettype wire

// ===== pkg/rf_pll_cfg_pkg.sv
// Package with register map, field layout and timing of the synthesizer configuration block.
package rf_pll_cfg_pkg;

   // Register byte addresses on the Wishbone bus, one aligned word each.
   localparam logic [7:0] ZERO_HIGH_OFS = 8'h00;
   localparam logic [7:0] ZERO_LOW_OFS  = 8'h04;
   localparam logic [7:0] ONE_HIGH_OFS  = 8'h08;
   localparam logic [7:0] ONE_LOW_OFS   = 8'h0c;
   localparam logic [7:0] CONTROL_OFS   = 8'h10;
   localparam logic [7:0] STATUS_OFS    = 8'h14;

   // Divider word layout: upper bits in one byte, lower bits in the next.
   localparam int FRAC_W        = 13;
   localparam int FRAC_HIGH_LSB = 5;
   localparam int FRAC_LOW_LSB  = 3;

   // Fields in the low bits of the two mixed bytes.
   localparam int INVERT_BIT = 2;
   localparam int CODE_LSB   = 0;
   localparam int BAND_BIT   = 2;
   localparam int KEYING_BIT = 1;
   localparam int REF_EN_BIT = 0;

   // Fields of the control and status words.
   localparam int CTRL_PAGE_BIT   = 0;
   localparam int CTRL_SRST_BIT   = 1;
   localparam int CTRL_DIRECT_BIT = 2;
   localparam int STAT_REF_BIT    = 0;
   localparam int STAT_DATA_BIT   = 1;
   localparam int STAT_CARRIER_BIT = 2;

   // Reset values of every configuration field but coding, which resets to CODE_MANCHESTER.
   localparam logic [12:0] FRAC_RST   = 13'h0000;
   localparam logic        INVERT_RST = 1'h0;
   localparam logic        BAND_RST   = 1'h0;
   localparam logic        KEYING_RST = 1'h0;
   localparam logic        REF_EN_RST = 1'h0;
   localparam logic        PAGE_RST   = 1'h0;
   localparam logic        DIRECT_RST = 1'h0;

   // Integer part of the divider: base plus step times band bit.
   localparam logic [4:0] INT_BASE_LOW  = 5'h0c;
   localparam logic [4:0] INT_BASE_STEP = 5'h04;

   // Timer reference: system clock rate and requested reference rate.
   localparam int CLK_HZ = 20_000_000;
   localparam int REF_HZ = 500_000;
   localparam int REF_HALF_CYCLES = CLK_HZ / (2 * REF_HZ);

   // Data encoding and source, in field order.
   typedef enum logic [1:0] {
      CODE_MANCHESTER,
      CODE_BIPHASE,
      CODE_NRZ,
      CODE_DIRECT
   } coding_t;

endpackage : rf_pll_cfg_pkg

// ===== core/symbol_encoder.sv
// Line encoder turning buffer bits or the direct bit into the RF symbol.
`timescale 1ns/10ps
`default_nettype none
module symbol_encoder
   import rf_pll_cfg_pkg::*;
(
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic soft_clear,
   input  wire logic half_bit_tick,
   input  wire logic buffer_bit,
   input  wire logic direct_bit,
   input  wire logic invert,
   input  wire coding_t coding,
   output logic      bit_take,
   output logic      symbol_level
);

   logic phase_reg;
   logic cur_bit_reg;
   logic level_reg;

   // NRZ consumes a bit every half period; the coded forms every second.
   always_comb begin
      bit_take = 1'b0;
      if (coding == CODE_NRZ) begin
         bit_take = half_bit_tick; // RL7
      end else if (coding != CODE_DIRECT) begin
         bit_take = half_bit_tick & phase_reg;
      end
   end

   // Half-bit phase; held at zero in direct mode so a switch starts cleanly.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_reg <= 1'b0;
      end else if (soft_clear || coding == CODE_DIRECT) begin
         phase_reg <= 1'b0;
      end else if (half_bit_tick) begin
         phase_reg <= ~phase_reg;
      end
   end

   // The bit is held over both halves of a Manchester or Bi-Phase symbol.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cur_bit_reg <= 1'b0;
      end else if (soft_clear) begin
         cur_bit_reg <= 1'b0;
      end else if (half_bit_tick && !phase_reg) begin
         cur_bit_reg <= buffer_bit;
      end
   end

   // Output level per coding; invert swaps polarity in direct, NRZ and Manchester, and swaps the symbols in Bi-Phase.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         level_reg <= 1'b0;
      end else if (soft_clear) begin
         level_reg <= 1'b0;
      end else begin
         case (coding) // RL6
            CODE_DIRECT: begin
               level_reg <= direct_bit ^ invert; // RL5
            end
            CODE_NRZ: begin
               if (half_bit_tick) begin
                  level_reg <= buffer_bit ^ invert; // RL5
               end
            end
            CODE_MANCHESTER: begin
               if (half_bit_tick && !phase_reg) begin
                  level_reg <= buffer_bit ^ invert; // RL5
               end else if (half_bit_tick) begin
                  level_reg <= ~cur_bit_reg ^ invert;
               end
            end
            default: begin
               // Bi-Phase: edge at every bit start, mid edge for one bit value.
               if (half_bit_tick && !phase_reg) begin
                  level_reg <= ~level_reg;
               end else if (half_bit_tick && (cur_bit_reg ^ invert)) begin
                  level_reg <= ~level_reg; // RL5
               end
            end
         endcase
      end
   end

   assign symbol_level = level_reg;

endmodule : symbol_encoder
`default_nettype wire

// ===== testbench/rf_pll_cfg_asserts.sv
// Checker of bus timing, synthesizer drive and reference clock behaviour.
`timescale 1ns/10ps
`default_nettype none
module rf_pll_cfg_checker
   import rf_pll_cfg_pkg::*;
(
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic        half_bit_tick,
   input wire logic        buffer_bit_take,
   input wire logic        transmitter_soft_reset,
   input wire logic        register_page_select,
   input wire logic [12:0] zero_symbol_divider_fraction,
   input wire logic [12:0] one_symbol_divider_fraction,
   input wire logic        carrier_band_select,
   input wire logic        keying_method_select,
   input wire logic        output_invert_select,
   input wire logic [1:0]  coding_select,
   input wire logic        timer_reference_enable,
   input wire logic [4:0]  divider_integer,
   input wire logic [12:0] divider_fraction,
   input wire logic        carrier_enable,
   input wire logic        rf_data,
   input wire logic        timer_reference_clock
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Length of the current high phase of the reference; too long to unroll.
   logic [5:0] hi_cnt_reg;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) hi_cnt_reg <= 6'h00;
      else if (timer_reference_clock) hi_cnt_reg <= hi_cnt_reg + 6'h01;
      else hi_cnt_reg <= 6'h00;
   end

   // Bus answer timing and the decoded configuration.
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack stayed high.");
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
      wb_ack_o)
      else $error("ack late.");
   band_int_a: assert property ($stable(carrier_band_select) |->
      divider_integer == (carrier_band_select ? 5'h10 : 5'h0c))
      else $error("integer divider wrong.");
   ook_carrier_a: assert property (!keying_method_select ##1
      !keying_method_select |-> carrier_enable == $past(rf_data))
      else $error("carrier does not key.");
   fsk_frac_a: assert property (keying_method_select ##1 keying_method_select
      |-> divider_fraction == ($past(rf_data) ?
      $past(one_symbol_divider_fraction) : $past(zero_symbol_divider_fraction)))
      else $error("fraction not shifted.");
   srst_clear_a: assert property (transmitter_soft_reset |->
      !(|{zero_symbol_divider_fraction, one_symbol_divider_fraction,
      carrier_band_select, keying_method_select, output_invert_select,
      coding_select, timer_reference_enable}))
      else $error("soft reset left a field set.");
   ref_off_a: assert property (!timer_reference_enable ##1
      !timer_reference_enable |-> !timer_reference_clock)
      else $error("reference runs while off.");
   ref_high_a: assert property ($fell(timer_reference_clock) &&
      timer_reference_enable |-> hi_cnt_reg == 6'h14)
      else $error("reference high phase wrong.");
   ref_bound_a: assert property (hi_cnt_reg <= 6'h14)
      else $error("reference high too long.");
   page_hold_a: assert property (register_page_select ##1
      register_page_select |-> $stable(zero_symbol_divider_fraction) &&
      $stable(one_symbol_divider_fraction))
      else $error("divider changed on page one.");
   nrz_take_a: assert property (coding_select == CODE_NRZ |->
      buffer_bit_take == half_bit_tick)
      else $error("bit not taken at tick.");

   // Main scenarios.
   srst_c: cover property (transmitter_soft_reset);
   fsk_c: cover property (keying_method_select && carrier_band_select);
   ref_c: cover property ($fell(timer_reference_clock));
endmodule : rf_pll_cfg_checker

bind rf_pll_modulation_config rf_pll_cfg_checker checker_i (
   .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .half_bit_tick(half_bit_tick),
   .buffer_bit_take(buffer_bit_take),
   .transmitter_soft_reset(transmitter_soft_reset),
   .register_page_select(register_page_select),
   .zero_symbol_divider_fraction(zero_symbol_divider_fraction),
   .one_symbol_divider_fraction(one_symbol_divider_fraction),
   .carrier_band_select(carrier_band_select),
   .keying_method_select(keying_method_select),
   .output_invert_select(output_invert_select),
   .coding_select(coding_select),
   .timer_reference_enable(timer_reference_enable),
   .divider_integer(divider_integer), .divider_fraction(divider_fraction),
   .carrier_enable(carrier_enable), .rf_data(rf_data),
   .timer_reference_clock(timer_reference_clock));
`default_nettype wire

// ===== testbench/test_rf_pll_modulation_config.sv
// Self-checking bench for the synthesizer configuration block.
`timescale 1ns/10ps
`default_nettype none
module test_rf_pll_modulation_config
   import rf_pll_cfg_pkg::*;
;
   logic        clk, sys_rst, cyc, stb, we, ack, tick, bit_in, take;
   logic        alt_wr, alt_rd, srst, page, band, key, inv, ref_en, car, rf;
   logic        ref_clk, alt_wr_seen, take_seen, srst_seen;
   logic [1:0]  coding;
   logic [3:0]  sel;
   logic [4:0]  d_int;
   logic [7:0]  adr, alt_rdata, alt_addr, alt_wdata;
   logic [12:0] zero, one, d_frac;
   logic [31:0] dat_i, dat_o, rdata;
   int          error_cnt, checked;

   rf_pll_modulation_config dut (.clk(clk), .sys_rst(sys_rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .alt_page_rdata(alt_rdata), .alt_page_wr(alt_wr), .alt_page_rd(alt_rd),
      .alt_page_addr(alt_addr), .alt_page_wdata(alt_wdata),
      .half_bit_tick(tick), .buffer_bit(bit_in), .buffer_bit_take(take),
      .transmitter_soft_reset(srst), .register_page_select(page),
      .zero_symbol_divider_fraction(zero), .one_symbol_divider_fraction(one),
      .carrier_band_select(band), .keying_method_select(key),
      .output_invert_select(inv), .coding_select(coding),
      .timer_reference_enable(ref_en), .divider_integer(d_int),
      .divider_fraction(d_frac), .carrier_enable(car), .rf_data(rf),
      .timer_reference_clock(ref_clk));

   // Free-running 20 MHz clock.
   always #25 clk = ~clk;

   task check(input string what, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task results();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results

   // Classic cycle: hold everything until ack is sampled, then release.
   task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_i <= d;
      do @(posedge clk); while (ack !== 1'b1);
      rdata = dat_o;
      {alt_wr_seen, srst_seen} = {alt_wr, srst};
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : xfer

   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      check("read", rdata, exp);
   endtask : rd_chk

   task idle();
      repeat (3) @(posedge clk);
      #1;
   endtask : idle

   // One half-bit tick; the take strobe is looked at inside its cycle.
   task pulse();
      @(posedge clk);
      tick <= 1'b1;
      #1 take_seen = take;
      @(posedge clk);
      tick <= 1'b0;
      idle();
   endtask : pulse

   task t_reset();
      check("int", d_int, 32'h0c);
      check("cfg", {zero, one, band, key, inv, coding, ref_en}, 0);
      for (int i = 0; i < 6; i++) rd_chk(8'(i * 4), 32'h0);
   endtask : t_reset

   task t_div();
      xfer(8'h00, 1'b1, 32'ha5);
      xfer(8'h04, 1'b1, 32'h98);
      xfer(8'h08, 1'b1, 32'h3c);
      xfer(8'h0c, 1'b1, 32'h56);
      check("zero", zero, {8'ha5, 5'h13});
      check("one", one, {8'h3c, 5'h0a});
      rd_chk(8'h0c, 32'h56);
      idle();
      check("int", d_int, 32'h10);
      check("car", car, 1);
      check("frac", d_frac, {8'ha5, 5'h13});
      xfer(8'h0c, 1'b1, 32'h50);
      idle();
      check("int", d_int, 32'h0c);
   endtask : t_div

   task t_page();
      xfer(8'h10, 1'b1, 32'h1);
      check("page", page, 1);
      xfer(8'h00, 1'b1, 32'h77);
      check("alt", alt_wr_seen, 1);
      check("altw", {alt_addr, alt_wdata}, 32'h0077);
      check("zero", zero, {8'ha5, 5'h13});
      alt_rdata <= 8'h5e;
      rd_chk(8'h00, 32'h5e);
      xfer(8'h10, 1'b1, 32'h0);
      xfer(8'h20, 1'b1, 32'hff);
      rd_chk(8'h20, 32'h0);
      rd_chk(8'h00, 32'ha5);
   endtask : t_page

   task t_direct();
      xfer(8'h04, 1'b1, 32'h03);
      xfer(8'h10, 1'b1, 32'h4);
      idle();
      check("rf", rf, 1);
      check("car", car, 1);
      xfer(8'h04, 1'b1, 32'h07);
      idle();
      check("rf", rf, 0);
      check("car", car, 0);
   endtask : t_direct

   // Second half of the loop runs inverted.
   task t_nrz();
      xfer(8'h04, 1'b1, 32'h02);
      for (int i = 0; i < 4; i++) begin
         if (i == 2) xfer(8'h04, 1'b1, 32'h06);
         bit_in <= i[0];
         pulse();
         check("nrz", rf, i[0] ^ (i >= 2));
         check("take", take_seen, 1);
      end
   endtask : t_nrz

   // Fields set, then soft reset, so the encoder starts on a bit boundary.
   task t_coded();
      logic r0;
      xfer(8'h0c, 1'b1, 32'hff);
      xfer(8'h10, 1'b1, 32'h2);
      check("srst", srst_seen, 1);
      check("cfg", {zero, one, band, key, inv, coding, ref_en}, 0);
      rd_chk(8'h10, 32'h0);
      bit_in <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (i == 2) xfer(8'h04, 1'b1, 32'h04);
         pulse();
         check("man", rf, i[0] ^ (i < 2));
      end
      xfer(8'h04, 1'b1, 32'h01);
      for (int i = 0; i < 2; i++) begin
         bit_in <= i[0];
         r0 = rf;
         pulse();
         pulse();
         check("bph", rf, r0 ^ !i[0]);
      end
   endtask : t_coded

   task measure(output int c, input logic lvl);
      c = 0;
      do begin
         @(posedge clk);
         #1 c++;
      end while (ref_clk === lvl && c < 60);
   endtask : measure

   task t_ref();
      int hi, lo;
      xfer(8'h0c, 1'b1, 32'h01);
      measure(lo, 1'b0);
      measure(hi, 1'b1);
      measure(lo, 1'b0);
      check("high", hi, 20);
      check("low", lo, 20);
      xfer(8'h0c, 1'b1, 32'h00);
      idle();
      check("off", ref_clk, 0);
   endtask : t_ref

   // Cuts a hang short; the tests need well under a tenth of this.
   initial begin
      #2000000;
      check("watchdog", 32'h0, 32'h1);
      results();
   end

   initial begin
      {clk, cyc, stb, we, tick, bit_in, adr, dat_i, alt_rdata} = 0;
      sel = 4'hf;
      sys_rst = 1'b1;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      #1 t_reset();
      t_div();
      t_page();
      t_direct();
      t_nrz();
      t_coded();
      t_ref();
      results();
   end
endmodule : test_rf_pll_modulation_config
`default_nettype wire
